// ===== design/afec_pkg.sv
package afec_pkg;

  // ==========================================================================
  // register map: printed offsets are word indexes, byte address is four times
  // ==========================================================================
  localparam logic [7:0] AFEC_IDX_INPUT_SEL = 8'h12;
  localparam logic [7:0] AFEC_IDX_MATCHING  = 8'h13;
  localparam logic [7:0] AFEC_IDX_BIAS2     = 8'h14;
  localparam logic [7:0] AFEC_ADDR_INPUT_SEL = {AFEC_IDX_INPUT_SEL[5:0], 2'b00};
  localparam logic [7:0] AFEC_ADDR_MATCHING  = {AFEC_IDX_MATCHING[5:0], 2'b00};
  localparam logic [7:0] AFEC_ADDR_BIAS2     = {AFEC_IDX_BIAS2[5:0], 2'b00};

  // reset values: recommended settings, fast reference charge for startup
  localparam logic [7:0] AFEC_RST_INPUT_SEL = 8'h00;
  localparam logic [7:0] AFEC_RST_MATCHING  = 8'h00;
  localparam logic [7:0] AFEC_RST_BIAS2     = 8'h00;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int AFEC_B_AIN1_CONV1   = 0;
  localparam int AFEC_B_AIN1_CONV2   = 1;
  localparam int AFEC_B_AIN2_CONV2_A = 2;
  localparam int AFEC_B_AIN2_CONV2_B = 3;
  localparam int AFEC_B_AIN3_CONV2_A = 4;
  localparam int AFEC_B_AIN3_CONV2_B = 5;
  localparam int AFEC_B_CONV1_SE     = 6;
  localparam int AFEC_B_CONV2_SE     = 7;
  localparam int AFEC_B_MATCH_DIS    = 0;
  localparam int AFEC_B_WAVG_DIS     = 1;
  localparam int AFEC_B_VREF_SLOW    = 3;
  localparam int AFEC_F_SUMMER_LO    = 0;
  localparam int AFEC_F_QUANT_LO     = 2;
  localparam int AFEC_F_INTEG3_LO    = 4;
  localparam int AFEC_F_REFBUF_LO    = 6;

  // bias level as a fraction of nominal, in tenths of a percent
  localparam logic [10:0] AFEC_PCT_130   = 11'h514;
  localparam logic [10:0] AFEC_PCT_100   = 11'h3e8;
  localparam logic [10:0] AFEC_PCT_70    = 11'h2bc;
  localparam logic [10:0] AFEC_PCT_137_5 = 11'h55f;
  localparam logic [10:0] AFEC_PCT_62_5  = 11'h271;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {
    AFEC_SEL_INPUT = 2'b00,
    AFEC_SEL_MATCH = 2'b01,
    AFEC_SEL_BIAS  = 2'b10,
    AFEC_SEL_NONE  = 2'b11
  } afec_sel_t;

  typedef enum logic [1:0] {
    AFEC_BIAS_BOOST   = 2'b00,
    AFEC_BIAS_NOMINAL = 2'b01,
    AFEC_BIAS_REDUCED = 2'b10
  } afec_bias_t;

  // address to register; misaligned or unknown words map to none
  function automatic afec_sel_t afec_decode(input logic [7:0] addr);
    afec_sel_t s;
    s = AFEC_SEL_NONE;
    if (addr == AFEC_ADDR_INPUT_SEL) s = AFEC_SEL_INPUT;
    if (addr == AFEC_ADDR_MATCHING) s = AFEC_SEL_MATCH;
    if (addr == AFEC_ADDR_BIAS2) s = AFEC_SEL_BIAS;
    return s;
  endfunction

endpackage

// ===== design/afec_regbus_if.sv
`timescale 1ns/1ps
// register access between bus front end and register core
interface afec_regbus_if;
  import afec_pkg::*;
  logic        wr_pulse;
  afec_sel_t   wr_sel;
  logic [7:0]  wdata;
  logic [7:0]  input_sel;
  logic [7:0]  matching;
  logic [7:0]  bias2;

  modport front (
    output wr_pulse,
    output wr_sel,
    output wdata,
    input  input_sel,
    input  matching,
    input  bias2
  );

  modport core (
    input  wr_pulse,
    input  wr_sel,
    input  wdata,
    output input_sel,
    output matching,
    output bias2
  );
endinterface

// ===== design/afec_apb_slave.sv
`timescale 1ns/1ps
module afec_apb_slave
  import afec_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // register core
  afec_regbus_if.front     bus
);

  // ==========================================================================
  // decode
  // ==========================================================================
  logic        setup_w;
  logic        access_w;
  afec_sel_t   sel_w;
  logic [7:0]  rd_w;
  logic [31:0] prdata_q;
  logic        err_q;

  assign setup_w  = psel & ~penable;
  assign access_w = psel & penable;
  assign sel_w    = afec_decode(paddr);

  // read mux; unmapped words read as zero
  always_comb begin
    rd_w = 8'h00;
    unique case (sel_w)
      AFEC_SEL_INPUT: rd_w = bus.input_sel;
      AFEC_SEL_MATCH: rd_w = bus.matching;
      AFEC_SEL_BIAS:  rd_w = bus.bias2;
      AFEC_SEL_NONE:  rd_w = 8'h00;
    endcase
  end

  // read data caught in setup so it leaves a flip-flop during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_w) begin
      prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_w};
    end
  end

  // unmapped address answers with an error, either direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (setup_w) begin
      err_q <= (sel_w == AFEC_SEL_NONE);
    end
  end

  // zero wait states: access always completes on its first edge
  assign pready  = 1'b1;
  assign pslverr = err_q & access_w;
  assign prdata  = prdata_q;

  // only lane 0 carries data; a write without it is accepted and dropped
  assign bus.wr_pulse = access_w & pwrite & pstrb[0] & (sel_w != AFEC_SEL_NONE);
  assign bus.wr_sel   = sel_w;
  assign bus.wdata    = pwdata[7:0];

endmodule

// ===== design/afec_regs.sv
`timescale 1ns/1ps
module afec_regs
  import afec_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // input routing
  output logic             ain1_to_conv1,
  output logic             ain1_to_conv2,
  output logic             ain2_to_conv2_a,
  output logic             ain2_to_conv2_b,
  output logic             ain3_to_conv2_a,
  output logic             ain3_to_conv2_b,
  output logic             conv1_single_ended,
  output logic             conv2_single_ended,
  // element matching and reference
  output logic             match_enable,
  output logic             wavg_enable,
  output logic             vref_slow_charge,
  // second_converter bias levels
  output afec_bias_t       summer_bias,
  output afec_bias_t       quant_bias,
  output afec_bias_t       integ3_bias,
  output afec_bias_t       refbuf_bias,
  output logic      [10:0] summer_pct_x10,
  output logic      [10:0] quant_pct_x10,
  output logic      [10:0] integ3_pct_x10,
  output logic      [10:0] refbuf_pct_x10,
  // update strobe
  output logic             cfg_update
);

  // ==========================================================================
  // helpers
  // ==========================================================================
  // 01 and 10 both mean nominal, so the two codes collapse to one level
  function automatic afec_bias_t bias_level(input logic [1:0] code);
    afec_bias_t l;
    l = AFEC_BIAS_NOMINAL;
    unique case (code)
      2'b00: l = AFEC_BIAS_BOOST;
      2'b01: l = AFEC_BIAS_NOMINAL;
      2'b10: l = AFEC_BIAS_NOMINAL;
      2'b11: l = AFEC_BIAS_REDUCED;
    endcase
    return l;
  endfunction

  // quantizer uses its own boost and cut figures
  function automatic logic [10:0] bias_pct(input logic [1:0] code, input logic quant);
    logic [10:0] p;
    p = AFEC_PCT_100;
    unique case (bias_level(code))
      AFEC_BIAS_BOOST:   p = quant ? AFEC_PCT_137_5 : AFEC_PCT_130;
      AFEC_BIAS_NOMINAL: p = AFEC_PCT_100;
      AFEC_BIAS_REDUCED: p = quant ? AFEC_PCT_62_5 : AFEC_PCT_70;
      default:           p = AFEC_PCT_100;
    endcase
    return p;
  endfunction

  // ==========================================================================
  // bus front end
  // ==========================================================================
  afec_regbus_if bus ();

  afec_apb_slave u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .bus     (bus)
  );

  // ==========================================================================
  // register storage
  // ==========================================================================
  logic [7:0]  input_sel_q;
  logic [7:0]  matching_q;
  logic [7:0]  bias2_q;
  logic        wr_input_w;
  logic        wr_match_w;
  logic        wr_bias_w;
  logic [7:0]  wd_w;

  assign wr_input_w = bus.wr_pulse & (bus.wr_sel == AFEC_SEL_INPUT);
  assign wr_match_w = bus.wr_pulse & (bus.wr_sel == AFEC_SEL_MATCH);
  assign wr_bias_w  = bus.wr_pulse & (bus.wr_sel == AFEC_SEL_BIAS);
  assign wd_w       = bus.wdata;

  // input selection register, whole byte kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_sel_q <= AFEC_RST_INPUT_SEL;
    end else if (wr_input_w) begin
      input_sel_q <= wd_w;
    end
  end

  // matching register; unused bits 2 and 7:4 are kept for readback only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      matching_q <= AFEC_RST_MATCHING;
    end else if (wr_match_w) begin
      matching_q <= wd_w;
    end
  end

  // second_converter bias register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias2_q <= AFEC_RST_BIAS2;
    end else if (wr_bias_w) begin
      bias2_q <= wd_w;
    end
  end

  assign bus.input_sel = input_sel_q;
  assign bus.matching  = matching_q;
  assign bus.bias2     = bias2_q;

  // ==========================================================================
  // input routing controls
  // ==========================================================================
  // both input 2 bits and both input 3 bits are separate switches; software
  // may close more than one path to the second converter, nothing prevents it
  assign ain1_to_conv1      = input_sel_q[AFEC_B_AIN1_CONV1];
  assign ain1_to_conv2      = input_sel_q[AFEC_B_AIN1_CONV2];
  assign ain2_to_conv2_a    = input_sel_q[AFEC_B_AIN2_CONV2_A];
  assign ain2_to_conv2_b    = input_sel_q[AFEC_B_AIN2_CONV2_B];
  assign ain3_to_conv2_a    = input_sel_q[AFEC_B_AIN3_CONV2_A];
  assign ain3_to_conv2_b    = input_sel_q[AFEC_B_AIN3_CONV2_B];
  assign conv1_single_ended = input_sel_q[AFEC_B_CONV1_SE];
  assign conv2_single_ended = input_sel_q[AFEC_B_CONV2_SE];

  // ==========================================================================
  // matching and reference charge controls
  // ==========================================================================
  // register bits are disables; outputs are active high enables
  assign match_enable     = ~matching_q[AFEC_B_MATCH_DIS];
  assign wavg_enable      = ~matching_q[AFEC_B_WAVG_DIS];
  // reset leaves fast charge; software moves to slow once the reference settles
  assign vref_slow_charge = matching_q[AFEC_B_VREF_SLOW];

  // ==========================================================================
  // bias decode, registered at the write edge
  // ==========================================================================
  // decoding from write data keeps level and percent in step with the byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summer_bias    <= AFEC_BIAS_BOOST;
      summer_pct_x10 <= AFEC_PCT_130;
    end else if (wr_bias_w) begin
      summer_bias    <= bias_level(wd_w[AFEC_F_SUMMER_LO +: 2]);
      summer_pct_x10 <= bias_pct(wd_w[AFEC_F_SUMMER_LO +: 2], 1'b0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quant_bias    <= AFEC_BIAS_BOOST;
      quant_pct_x10 <= AFEC_PCT_137_5;
    end else if (wr_bias_w) begin
      quant_bias    <= bias_level(wd_w[AFEC_F_QUANT_LO +: 2]);
      quant_pct_x10 <= bias_pct(wd_w[AFEC_F_QUANT_LO +: 2], 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ3_bias    <= AFEC_BIAS_BOOST;
      integ3_pct_x10 <= AFEC_PCT_130;
    end else if (wr_bias_w) begin
      integ3_bias    <= bias_level(wd_w[AFEC_F_INTEG3_LO +: 2]);
      integ3_pct_x10 <= bias_pct(wd_w[AFEC_F_INTEG3_LO +: 2], 1'b0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refbuf_bias    <= AFEC_BIAS_BOOST;
      refbuf_pct_x10 <= AFEC_PCT_130;
    end else if (wr_bias_w) begin
      refbuf_bias    <= bias_level(wd_w[AFEC_F_REFBUF_LO +: 2]);
      refbuf_pct_x10 <= bias_pct(wd_w[AFEC_F_REFBUF_LO +: 2], 1'b0);
    end
  end

  // ==========================================================================
  // update strobe
  // ==========================================================================
  // one cycle after any write to a mapped register with lane 0 strobed, when the new controls stand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_update <= 1'b0;
    end else begin
      cfg_update <= bus.wr_pulse;
    end
  end

endmodule

// ===== tb/afec_regs_checker.sv
`timescale 1ns/1ps
module afec_regs_checker
  import afec_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // update strobe
  input wire logic        cfg_update,
  // input routing
  input wire logic        ain1_to_conv1,
  input wire logic        ain1_to_conv2,
  input wire logic        ain2_to_conv2_a,
  input wire logic        ain2_to_conv2_b,
  input wire logic        ain3_to_conv2_a,
  input wire logic        ain3_to_conv2_b,
  input wire logic        conv1_single_ended,
  input wire logic        conv2_single_ended,
  // element matching and reference
  input wire logic        match_enable,
  input wire logic        wavg_enable,
  input wire logic        vref_slow_charge,
  // bias levels
  input wire afec_bias_t  summer_bias,
  input wire afec_bias_t  quant_bias,
  input wire afec_bias_t  integ3_bias,
  input wire afec_bias_t  refbuf_bias,
  input wire logic [10:0] summer_pct_x10,
  input wire logic [10:0] quant_pct_x10,
  input wire logic [10:0] integ3_pct_x10,
  input wire logic [10:0] refbuf_pct_x10
);
  // ==========================================================================
  // helpers
  // ==========================================================================
  wire logic [7:0] route = {conv2_single_ended, conv1_single_ended, ain3_to_conv2_b, ain3_to_conv2_a,
                            ain2_to_conv2_b, ain2_to_conv2_a, ain1_to_conv2, ain1_to_conv1};
  wire logic [18:0] ctrl = {route, match_enable, wavg_enable, vref_slow_charge, summer_bias, quant_bias,
                            integ3_bias, refbuf_bias};
  wire logic acc = psel & penable & pwrite & pstrb[0];
  wire logic mapped = paddr == AFEC_ADDR_INPUT_SEL || paddr == AFEC_ADDR_MATCHING || paddr == AFEC_ADDR_BIAS2;
  // field code to level, decoded here so a slip in the design shows
  function automatic afec_bias_t cb(input logic [1:0] c);
    return c == 2'b00 ? AFEC_BIAS_BOOST : (c == 2'b11 ? AFEC_BIAS_REDUCED : AFEC_BIAS_NOMINAL);
  endfunction
  function automatic logic [10:0] pc(input afec_bias_t b, input logic q);
    if (b == AFEC_BIAS_BOOST) return q ? AFEC_PCT_137_5 : AFEC_PCT_130;
    if (b == AFEC_BIAS_REDUCED) return q ? AFEC_PCT_62_5 : AFEC_PCT_70;
    return AFEC_PCT_100;
  endfunction
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr_to(logic [7:0] a);
    acc && paddr == a;
  endsequence
  // ==========================================================================
  // properties
  // ==========================================================================
  route_follows_a: assert property (wr_to(AFEC_ADDR_INPUT_SEL) |=> route == $past(pwdata[7:0]))
    else $error("routing outputs differ from written byte");
  match_follows_a: assert property (wr_to(AFEC_ADDR_MATCHING) |=>
    {match_enable, wavg_enable, vref_slow_charge} == {!$past(pwdata[0]), !$past(pwdata[1]), $past(pwdata[3])})
    else $error("matching outputs differ from written byte");
  bias_code_a: assert property (wr_to(AFEC_ADDR_BIAS2) |=>
    {refbuf_bias, integ3_bias, quant_bias, summer_bias} ==
    {cb($past(pwdata[7:6])), cb($past(pwdata[5:4])), cb($past(pwdata[3:2])), cb($past(pwdata[1:0]))})
    else $error("bias level differs from field code");
  pct_level_a: assert property (
    summer_pct_x10 == pc(summer_bias, 1'b0) && quant_pct_x10 == pc(quant_bias, 1'b1) &&
    integ3_pct_x10 == pc(integ3_bias, 1'b0) && refbuf_pct_x10 == pc(refbuf_bias, 1'b0))
    else $error("bias percentage differs from level");
  ctrl_hold_a: assert property (!acc |=> $stable(ctrl))
    else $error("control moved without a write");
  update_cause_a: assert property (cfg_update |-> $past(psel && penable && pwrite && !pslverr))
    else $error("update pulse without a write");
  update_pulse_a: assert property (acc && mapped |=> cfg_update)
    else $error("no update pulse after write");
  bad_addr_a: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  good_addr_a: assert property (psel && penable && mapped |-> !pslverr && pready)
    else $error("mapped access refused");
  read_back_a: assert property (
    psel && penable && !pwrite && paddr == AFEC_ADDR_INPUT_SEL |-> prdata == {24'h0, route})
    else $error("read data differs from routing state");
endmodule

bind afec_regs afec_regs_checker i_afec_regs_checker (.*);

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import afec_pkg::*;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cfg_update, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        ain1_to_conv1, ain1_to_conv2, ain2_to_conv2_a, ain2_to_conv2_b;
  logic        ain3_to_conv2_a, ain3_to_conv2_b, conv1_single_ended, conv2_single_ended;
  logic        match_enable, wavg_enable, vref_slow_charge;
  afec_bias_t  summer_bias, quant_bias, integ3_bias, refbuf_bias;
  logic [10:0] summer_pct_x10, quant_pct_x10, integ3_pct_x10, refbuf_pct_x10;
  logic [7:0]  m [3];
  logic [7:0]  ad [3] = '{AFEC_ADDR_INPUT_SEL, AFEC_ADDR_MATCHING, AFEC_ADDR_BIAS2};
  logic [7:0]  bad [4] = '{8'h44, 8'h49, 8'h54, 8'hff};
  int          errors, total_checks, cycles;

  afec_regs i_afec_regs (.*);

  // ==========================================================================
  // clock, watchdog, checks
  // ==========================================================================
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // about 240 cycles expected; generous ceiling
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========================================================================
  // expectations
  // ==========================================================================
  function automatic afec_bias_t eb(input logic [1:0] c);
    return c == 2'b00 ? AFEC_BIAS_BOOST : (c == 2'b11 ? AFEC_BIAS_REDUCED : AFEC_BIAS_NOMINAL);
  endfunction
  function automatic logic [10:0] ep(input logic [1:0] c, input logic q);
    if (c == 2'b00) return q ? AFEC_PCT_137_5 : AFEC_PCT_130;
    if (c == 2'b11) return q ? AFEC_PCT_62_5 : AFEC_PCT_70;
    return AFEC_PCT_100;
  endfunction
  task automatic chk_outs();
    logic [7:0]  rt_s;
    logic [7:0]  bl_e;
    logic [7:0]  bl_s;
    logic [43:0] pc_e;
    logic [43:0] pc_s;
    // gather seen and expected first so each compare stays on one line
    rt_s = {conv2_single_ended, conv1_single_ended, ain3_to_conv2_b, ain3_to_conv2_a,
            ain2_to_conv2_b, ain2_to_conv2_a, ain1_to_conv2, ain1_to_conv1};
    bl_e = {eb(m[2][7:6]), eb(m[2][5:4]), eb(m[2][3:2]), eb(m[2][1:0])};
    bl_s = {refbuf_bias, integ3_bias, quant_bias, summer_bias};
    pc_e = {ep(m[2][7:6], 1'b0), ep(m[2][5:4], 1'b0), ep(m[2][3:2], 1'b1), ep(m[2][1:0], 1'b0)};
    pc_s = {refbuf_pct_x10, integ3_pct_x10, quant_pct_x10, summer_pct_x10};
    chk("routing", m[0], rt_s);
    chk("matching", {~m[1][0], ~m[1][1], m[1][3]}, {match_enable, wavg_enable, vref_slow_charge});
    chk("bias", bl_e, bl_s);
    chk("pct", pc_e, pc_s);
  endtask
  task automatic chk_regs(input string nm);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ad[i], 32'h0, 4'hf);
      chk("read", {24'h0, m[i]}, rd);
    end
    $display("test %s done", nm);
  endtask
  // a write that the model follows only when the low lane is strobed
  task automatic wr(input int i, input logic [7:0] v, input logic [3:0] st);
    apb(1'b1, ad[i], {24'($urandom), v}, st);
    if (st[0]) m[i] = v;
    #1;
    chk("cfg_update", st[0], cfg_update);
    chk("slverr", 1'b0, er);
    chk_outs();
  endtask
  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    {errors, total_checks, cycles} = '0;
    {psel, penable, pwrite, paddr, pwdata, pstrb, presetn} = '0;
    m = '{default: 8'h00};
    void'($urandom(18943));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk_outs();
    chk_regs("reset");
    // every code in every bias field, walking ones, matching corners
    for (int c = 0; c < 4; c++) wr(2, {4{c[1:0]}}, 4'h1);
    for (int b = 0; b < 8; b++) wr(0, 8'h01 << b, 4'hf);
    wr(1, 8'hff, 4'hf);
    wr(1, 8'h08, 4'hf);
    chk_regs("corners");
    // random writes, some with the low lane unstrobed
    repeat (40) wr($urandom_range(2, 0), 8'($urandom), ($urandom_range(3, 0) == 0) ? 4'he : 4'hf);
    chk_regs("random");
    // refused addresses leave everything untouched
    foreach (bad[k]) begin
      apb(1'b1, bad[k], 32'hff, 4'hf);
      chk("slverr", 1'b1, er);
      apb(1'b0, bad[k], 32'h0, 4'hf);
      chk("bad read", {33'h1_0000_0000}, {er, rd});
    end
    #1;
    chk_outs();
    chk_regs("unmapped");
    // reset in mid-run brings every register back to its recommended value
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    m = '{default: 8'h00};
    #1;
    chk_outs();
    chk_regs("mid reset");
    complete_run();
  end
endmodule
